/* File: master_model.sv */
// fieldbus master model that drives the probe control word
`timescale 1ns/1ns
module master_model (
    input  wire         i_clk,
    output logic [15:0] o_ctrl_word
);
    initial o_ctrl_word = 16'h0000;
    // separate enable bits per probe and per edge
    task put(input logic [15:0] w);
        @(posedge i_clk);
        #1 o_ctrl_word = w;
    endtask
endmodule // master_model

/* File: probe_capture_checker.sv */
// assertions on the touch-probe capture ports
`timescale 1ns/1ns
module probe_capture_checker (
    input logic        i_clk,
    input logic        i_rstn,
    input logic [15:0] i_ctrl_word,
    input logic [31:0] i_position,
    input logic        i_probe1,
    input logic        i_probe2,
    input logic        i_index_pulse,
    input logic [15:0] o_status_word,
    input logic [31:0] o_probe1_fall_position,
    input logic [31:0] o_probe2_rise_position,
    input logic [15:0] o_probe1_rise_count,
    input logic [15:0] o_probe2_fall_count
);
    // mirrors two sync flops plus history, so edges land on the design's edge
    logic [8:0] h_q;
    wire [15:0] c = i_ctrl_word;
    wire [15:0] s = o_status_word;
    wire e1 = c[0] & ~c[2];
    wire e2 = c[8] & ~c[10];
    always @(posedge i_clk or negedge i_rstn)
        if (!i_rstn) h_q <= 9'h000;
        else h_q <= {h_q[7:6], i_index_pulse, h_q[4:3], i_probe2, h_q[1:0], i_probe1};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence off1; !c[0]; endsequence
    p1_fall_a: assert property (
        h_q[2] & ~h_q[1] & e1 & c[5] & (c[1] | ~s[2]) |=> o_probe1_fall_position == $past(i_position))
        else $error("probe 1 fall position wrong");
    p2_rise_a: assert property (
        h_q[4] & ~h_q[5] & e2 & c[12] & (c[9] | ~s[9]) |=> o_probe2_rise_position == $past(i_position))
        else $error("probe 2 rise position wrong");
    p1_rise_cnt_a: assert property (
        h_q[1] & ~h_q[2] & e1 & c[4] & (c[1] | ~s[1]) |=> o_probe1_rise_count == $past(o_probe1_rise_count) + 16'h0001)
        else $error("probe 1 rise count wrong");
    p2_fall_cnt_a: assert property (
        h_q[5] & ~h_q[4] & e2 & c[13] & (c[9] | ~s[10]) |=> o_probe2_fall_count == $past(o_probe2_fall_count) + 16'h0001)
        else $error("probe 2 fall count wrong");
    edge_off_a: assert property (!c[4] |=> $stable(o_probe1_rise_count)) else $error("disabled edge counted");
    single_hold_a: assert property (c[0] & ~c[1] & s[1] |=> $stable(o_probe1_rise_count)) else $error("single relatched");
    index_src_a: assert property (c[2] & ~(h_q[7] & ~h_q[8]) |=> $stable(o_probe1_rise_count)) else $error("pin used");
    status_off_a: assert property (off1 |=> s[2:0] == 3'h0) else $error("status not cleared");
endmodule // probe_capture_checker
bind touch_probe_position_capture probe_capture_checker probe_capture_checker_inst (.i_clk, .i_rstn, .i_ctrl_word,
    .i_position, .i_probe1, .i_probe2, .i_index_pulse, .o_status_word, .o_probe1_fall_position,
    .o_probe2_rise_position, .o_probe1_rise_count, .o_probe2_fall_count);

/* File: probe_capture_regs.vh */
// register indices, field positions and reset values of the touch-probe capture unit
`ifndef PROBE_CAPTURE_REGS_VH
`define PROBE_CAPTURE_REGS_VH

`define PROBE_CTRL_IDX        16'h60B8
`define PROBE_STAT_IDX        16'h60B9
`define PROBE1_RISE_POS_IDX   16'h60BA
`define PROBE1_FALL_POS_IDX   16'h60BB
`define PROBE2_RISE_POS_IDX   16'h60BC
`define PROBE2_FALL_POS_IDX   16'h60BD
`define PROBE1_RISE_CNT_IDX   16'h60D5
`define PROBE1_FALL_CNT_IDX   16'h60D6
`define PROBE2_RISE_CNT_IDX   16'h60D7
`define PROBE2_FALL_CNT_IDX   16'h60D7

// control word fields, per probe, relative to the probe's byte
`define CTRL_ENABLE_BIT       0
`define CTRL_CONT_BIT         1
`define CTRL_SRC_INDEX_BIT    2
`define CTRL_RISE_EN_BIT      4
`define CTRL_FALL_EN_BIT      5
// probe 2 fields sit one byte above probe 1, in both words
`define PROBE2_OFS            8
// status word fields, per probe, relative to the probe's byte
`define STAT_ENABLED_BIT      0
`define STAT_RISE_LATCHED_BIT 1
`define STAT_FALL_LATCHED_BIT 2

`define POS_RESET             32'h0000_0000
`define CNT_RESET             16'h0000
`define STAT_RESET            16'h0000

`endif

/* File: testbench.sv */
// self-checking bench for the touch-probe capture unit
`timescale 1ns/1ns
module testbench;
    logic i_clk = 0, i_rstn = 0, i_probe1 = 0, i_probe2 = 0, i_index_pulse = 0;
    logic [15:0] i_ctrl_word, st, c1r, c1f, c2r, c2f;
    logic [31:0] i_position = 32'h0000_0000, p1r, p1f, p2r, p2f;
    int failures = 0, num_checks = 0, cyc = 0;
    always #20 i_clk = ~i_clk;
    master_model master_model_inst (.i_clk, .o_ctrl_word(i_ctrl_word));
    touch_probe_position_capture touch_probe_position_capture_inst (.i_clk, .i_rstn, .i_ctrl_word, .i_position,
        .i_probe1, .i_probe2, .i_index_pulse, .o_status_word(st), .o_probe1_rise_position(p1r),
        .o_probe1_fall_position(p1f), .o_probe2_rise_position(p2r), .o_probe2_fall_position(p2f),
        .o_probe1_rise_count(c1r), .o_probe1_fall_count(c1f), .o_probe2_rise_count(c2r), .o_probe2_fall_count(c2f));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    // a pin change shows three edges later
    task setp(input logic [2:0] v);
        @(posedge i_clk);
        #1 {i_index_pulse, i_probe2, i_probe1} = v;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task t_cont;
        master_model_inst.put(16'h3333);
        i_position = 32'h8000_0005;
        setp(3'h1);
        setp(3'h0);
        chk("p1f", 32'h8000_0005, p1f);
        chk("p1r", 32'h8000_0005, p1r);
        chk("c1", 32'h0001_0001, {c1r, c1f});
        i_position = 32'h1234_5678;
        setp(3'h2);
        chk("p2r", 32'h1234_5678, p2r);
        setp(3'h0);
        chk("p2f", 32'h1234_5678, p2f);
        chk("c2", 32'h0001_0001, {c2r, c2f});
        chk("st", 32'h0000_0707, {16'h0000, st});
    endtask
    task t_single;
        master_model_inst.put(16'h0000);
        master_model_inst.put(16'h0011);
        i_position = 32'h0000_00aa;
        setp(3'h1);
        setp(3'h0);
        i_position = 32'h0000_00bb;
        setp(3'h1);
        chk("p1r", 32'h0000_00aa, p1r);
        chk("c1r", 32'h0000_0002, {16'h0000, c1r});
        chk("st", 32'h0000_0003, {16'h0000, st});
    endtask
    task t_source;
        master_model_inst.put(16'h0017);
        setp(3'h0);
        setp(3'h1);
        chk("c1r", 32'h0000_0002, {16'h0000, c1r});
        setp(3'h5);
        chk("c1r", 32'h0000_0003, {16'h0000, c1r});
        master_model_inst.put(16'h0007);
        setp(3'h1);
        setp(3'h5);
        chk("c1r", 32'h0000_0003, {16'h0000, c1r});
    endtask
    task t_probe2;
        master_model_inst.put(16'h2500);
        i_position = 32'h0000_0cc0;
        setp(3'h0);
        i_position = 32'h0000_0dd0;
        setp(3'h4);
        setp(3'h0);
        chk("p2f", 32'h0000_0cc0, p2f);
        chk("c2f", 32'h0000_0002, {16'h0000, c2f});
        chk("c2r", 32'h0000_0001, {16'h0000, c2r});
        chk("st", 32'h0000_0500, {16'h0000, st});
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        #1 i_rstn = 1;
        chk("c2", 32'h0000_0000, {c2r, c2f});
        t_cont;
        t_single;
        t_source;
        t_probe2;
        end_of_test;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 2000) begin
            failures++;
            end_of_test;
        end
    end
endmodule // testbench

/* File: touch_probe_position_capture.v */
// touch-probe position capture with edge counters and status word
// Operation
// - a falling edge of probe 1 latches the signed 32-bit position into the probe 1 falling result.
// - a rising edge of probe 2 latches the signed 32-bit position into the probe 2 rising result.
// - a 16-bit read-only count, reset to zero, tracks probe 1 rising-edge latches.
// - a 16-bit read-only count, reset to zero, tracks probe 2 rising-edge latches.
// - a 16-bit read-only count, reset to zero, tracks probe 2 falling-edge latches.
// - each probe and each of its edges has an enable bit, and only enabled edges latch.
// - a trigger-mode bit picks single capture (once per enable) or continuous capture.
// - a source-select bit picks the probe input or the encoder index pulse as trigger.
// - the status word shows each probe's enable and its rising and falling latched flags.
`timescale 1ns/1ns
`include "probe_capture_regs.vh"

module touch_probe_position_capture (
    input  wire        i_clk,
    input  wire        i_rstn,
    input  wire [15:0] i_ctrl_word,
    input  wire [31:0] i_position,
    input  wire        i_probe1,
    input  wire        i_probe2,
    input  wire        i_index_pulse,
    output wire [15:0] o_status_word,
    output wire [31:0] o_probe1_rise_position,
    output wire [31:0] o_probe1_fall_position,
    output wire [31:0] o_probe2_rise_position,
    output wire [31:0] o_probe2_fall_position,
    output wire [15:0] o_probe1_rise_count,
    output wire [15:0] o_probe1_fall_count,
    output wire [15:0] o_probe2_rise_count,
    output wire [15:0] o_probe2_fall_count
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers: pins pass two flops before any logic reads them

reg [2:0] sync1_q;
reg [2:0] sync2_q;
// third flop only keeps last cycle's level for the edge detectors
reg [2:0] prev_q;

always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        sync1_q <= 3'h0;
        sync2_q <= 3'h0;
        prev_q  <= 3'h0;
    end else begin
        sync1_q <= {i_index_pulse, i_probe2, i_probe1};
        sync2_q <= sync1_q;
        prev_q  <= sync2_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// per-probe trigger selection and edge qualification

wire [7:0] ctl1 = i_ctrl_word[7:0];
wire [7:0] ctl2 = i_ctrl_word[15:8];

// source mux: probe pin or encoder index pulse
function trig_now;
    input [7:0] ctl;
    input       pin;
    input       idx;
    begin
        trig_now = ctl[`CTRL_SRC_INDEX_BIT] ? idx : pin;
    end
endfunction

// trigger level now and one cycle back
wire t1_now  = trig_now(ctl1, sync2_q[0], sync2_q[2]);
wire t1_prev = trig_now(ctl1, prev_q[0], prev_q[2]);
wire t2_now  = trig_now(ctl2, sync2_q[1], sync2_q[2]);
wire t2_prev = trig_now(ctl2, prev_q[1], prev_q[2]);

// edges compare the synchronised level against the history flop
wire t1_rise = t1_now & ~t1_prev;
wire t1_fall = ~t1_now & t1_prev;
wire t2_rise = t2_now & ~t2_prev;
wire t2_fall = ~t2_now & t2_prev;

reg [15:0] stat_q;

// qualify an edge: probe on, edge enabled, and in single mode not yet latched
function qualify;
    input [7:0] ctl;
    input       edge_seen;
    input       edge_bit;
    input       latched;
    begin
        qualify = ctl[`CTRL_ENABLE_BIT] & ctl[edge_bit ? `CTRL_FALL_EN_BIT : `CTRL_RISE_EN_BIT]
                  & edge_seen & (ctl[`CTRL_CONT_BIT] | ~latched);
    end
endfunction

// edge selectors for the qualifier
localparam SEL_RISE = 1'b0;
localparam SEL_FALL = 1'b1;

wire p1_rise = qualify(ctl1, t1_rise, SEL_RISE, stat_q[`STAT_RISE_LATCHED_BIT]);
wire p1_fall = qualify(ctl1, t1_fall, SEL_FALL, stat_q[`STAT_FALL_LATCHED_BIT]);
wire p2_rise = qualify(ctl2, t2_rise, SEL_RISE, stat_q[`PROBE2_OFS + `STAT_RISE_LATCHED_BIT]);
wire p2_fall = qualify(ctl2, t2_fall, SEL_FALL, stat_q[`PROBE2_OFS + `STAT_FALL_LATCHED_BIT]);

////////////////////////////////////////////////////////////////////////////////
// result latches, counters and status

reg [31:0] p1_rise_pos_q;
reg [31:0] p1_fall_pos_q;
reg [31:0] p2_rise_pos_q;
reg [31:0] p2_fall_pos_q;
reg [15:0] p1_rise_cnt_q;
reg [15:0] p1_fall_cnt_q;
reg [15:0] p2_rise_cnt_q;
reg [15:0] p2_fall_cnt_q;
reg [15:0] stat_d;
reg [31:0] p1_rise_pos_d;
reg [31:0] p1_fall_pos_d;
reg [31:0] p2_rise_pos_d;
reg [31:0] p2_fall_pos_d;
reg [15:0] p1_rise_cnt_d;
reg [15:0] p1_fall_cnt_d;
reg [15:0] p2_rise_cnt_d;
reg [15:0] p2_fall_cnt_d;

wire probe1_on = ctl1[`CTRL_ENABLE_BIT];
wire probe2_on = ctl2[`CTRL_ENABLE_BIT];

// one more latch; a full count rolls over to zero instead of sticking at the top
function [15:0] count_up;
    input [15:0] cnt;
    begin
        count_up = cnt + 16'h0001;
    end
endfunction

// latched flag: set by a hit, kept only while the probe stays enabled
function flag_next;
    input enabled;
    input held;
    input hit;
    begin
        flag_next = enabled & (held | hit);
    end
endfunction

// latched flags clear while the probe is disabled, which re-arms single mode;
// an edge in the same cycle cannot occur since it needs the enable
always @* begin
    // reserved bits stay zero
    stat_d = `STAT_RESET;
    stat_d[`STAT_ENABLED_BIT] = probe1_on;
    stat_d[`STAT_RISE_LATCHED_BIT] = flag_next(probe1_on, stat_q[`STAT_RISE_LATCHED_BIT], p1_rise);
    stat_d[`STAT_FALL_LATCHED_BIT] = flag_next(probe1_on, stat_q[`STAT_FALL_LATCHED_BIT], p1_fall);
    stat_d[`PROBE2_OFS + `STAT_ENABLED_BIT] = probe2_on;
    stat_d[`PROBE2_OFS + `STAT_RISE_LATCHED_BIT] =
        flag_next(probe2_on, stat_q[`PROBE2_OFS + `STAT_RISE_LATCHED_BIT], p2_rise);
    stat_d[`PROBE2_OFS + `STAT_FALL_LATCHED_BIT] =
        flag_next(probe2_on, stat_q[`PROBE2_OFS + `STAT_FALL_LATCHED_BIT], p2_fall);
end

// positions and counts hold unless a qualified edge arrives
always @* begin
    p1_rise_pos_d = p1_rise_pos_q;
    p1_fall_pos_d = p1_fall_pos_q;
    p2_rise_pos_d = p2_rise_pos_q;
    p2_fall_pos_d = p2_fall_pos_q;
    p1_rise_cnt_d = p1_rise_cnt_q;
    p1_fall_cnt_d = p1_fall_cnt_q;
    p2_rise_cnt_d = p2_rise_cnt_q;
    p2_fall_cnt_d = p2_fall_cnt_q;
    if (p1_rise) begin
        p1_rise_pos_d = i_position;
        p1_rise_cnt_d = count_up(p1_rise_cnt_q);
    end
    if (p1_fall) begin
        p1_fall_pos_d = i_position;
        p1_fall_cnt_d = count_up(p1_fall_cnt_q);
    end
    if (p2_rise) begin
        p2_rise_pos_d = i_position;
        p2_rise_cnt_d = count_up(p2_rise_cnt_q);
    end
    if (p2_fall) begin
        p2_fall_pos_d = i_position;
        p2_fall_cnt_d = count_up(p2_fall_cnt_q);
    end
end

// every result register reloads from its next value on each clock
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        p1_rise_pos_q <= `POS_RESET;
        p1_fall_pos_q <= `POS_RESET;
        p2_rise_pos_q <= `POS_RESET;
        p2_fall_pos_q <= `POS_RESET;
        p1_rise_cnt_q <= `CNT_RESET;
        p1_fall_cnt_q <= `CNT_RESET;
        p2_rise_cnt_q <= `CNT_RESET;
        p2_fall_cnt_q <= `CNT_RESET;
        stat_q        <= `STAT_RESET;
    end else begin
        stat_q        <= stat_d;
        p1_rise_pos_q <= p1_rise_pos_d;
        p1_fall_pos_q <= p1_fall_pos_d;
        p2_rise_pos_q <= p2_rise_pos_d;
        p2_fall_pos_q <= p2_fall_pos_d;
        p1_rise_cnt_q <= p1_rise_cnt_d;
        p1_fall_cnt_q <= p1_fall_cnt_d;
        p2_rise_cnt_q <= p2_rise_cnt_d;
        p2_fall_cnt_q <= p2_fall_cnt_d;
    end
end

// outputs come straight from flops, so the master never reads a half-updated word
assign o_status_word          = stat_q;
assign o_probe1_rise_position = p1_rise_pos_q;
assign o_probe1_fall_position = p1_fall_pos_q;
assign o_probe2_rise_position = p2_rise_pos_q;
assign o_probe2_fall_position = p2_fall_pos_q;
assign o_probe1_rise_count    = p1_rise_cnt_q;
assign o_probe1_fall_count    = p1_fall_cnt_q;
assign o_probe2_rise_count    = p2_rise_cnt_q;
assign o_probe2_fall_count    = p2_fall_cnt_q;

endmodule // touch_probe_position_capture
